// >>> rtl/iac_cfg.svh
// Constants shared by both ends of the interleaved converter link.
// Assumes a single 40 MHz system clock on both ends.
`ifndef IAC_CFG_SVH
`define IAC_CFG_SVH
`define IAC_CLK_KHZ 40000
`define IAC_LATENCY 15
`define IAC_CORES 2
`define IAC_FULL_SCALE 12'hfff
`define IAC_CAL_NOM_MS 200
`define IAC_CAL_MAX_MS 550
`define IAC_POR_CYCLES 16
`define IAC_SAMPLE_HALF 2
`define IAC_REG_CTRL 8'h00
`define IAC_REG_STATUS 8'h04
`define IAC_REG_SAMPLE 8'h08
`define IAC_REG_COUNT 8'h0c
`define IAC_CTRL_DIV 1:0
`define IAC_CTRL_STYLE 3:2
`define IAC_CTRL_POWER 5:4
`define IAC_CTRL_FMT 7:6
`define IAC_CTRL_RECAL 8
`define IAC_CTRL_RESET 8'h55
`endif

// >>> rtl/iac_pkg.sv
// Types shared by both ends of the interleaved converter link.
// Assumes iac_cfg.svh is on the include path.
package iac_pkg;
  // Three-level strap as seen by the logic: tied low, left open, tied high.
  typedef enum logic [1:0] {
    STRAP_LOW = 2'h0,
    STRAP_OPEN = 2'h1,
    STRAP_HIGH = 2'h2
  } iac_strap_type;
  typedef enum logic [1:0] {
    ST_HOLD = 2'h0,
    ST_CAL = 2'h1,
    ST_RUN = 2'h3
  } iac_cal_state_type;
endpackage

// >>> rtl/iac_link_if.sv
// Pin-level link between the converter and its capture logic.
// Assumes both ends run on the same sys_clk; open-drain lines resolve here.
`timescale 1ns/1ps
interface iac_link_if;
  import iac_pkg::*;
  logic sampleClk;
  iac_strap_type dividerStrap;
  iac_strap_type outputStyleStrap;
  iac_strap_type powerStateStrap;
  iac_strap_type codeFormatStrap;
  logic hostRstOe;
  logic devRstOe;
  logic resetPin;
  logic [11:0] dataOut;
  logic [11:0] dataOutN;
  logic ovr;
  logic ovrN;
  logic outClk;
  logic outClkN;
  logic serialSelectLow;
  logic serialClk;
  logic hostSdioOut;
  logic hostSdioOe;
  logic devSdioOut;
  logic devSdioOe;
  logic sdioPin;
  logic devSerialOut;
  logic devSerialOe;
  logic serialOutPin;
  // Weak pull-ups: any driver pulls the open-drain reset low.
  assign resetPin = ~(hostRstOe | devRstOe);
  assign serialOutPin = devSerialOe ? devSerialOut : 1'b1;
  assign sdioPin = devSdioOe ? devSdioOut : (hostSdioOe ? hostSdioOut : 1'b1);
  modport dev (
    input sampleClk, dividerStrap, outputStyleStrap, powerStateStrap, codeFormatStrap,
    input resetPin, serialOutPin, serialSelectLow, serialClk, sdioPin,
    output devRstOe, dataOut, dataOutN, ovr, ovrN, outClk, outClkN,
    output devSdioOut, devSdioOe, devSerialOut, devSerialOe
  );
  modport host (
    output sampleClk, dividerStrap, outputStyleStrap, powerStateStrap, codeFormatStrap,
    output hostRstOe, serialSelectLow, serialClk, hostSdioOut, hostSdioOe,
    input resetPin, serialOutPin, sdioPin, dataOut, dataOutN, ovr, ovrN, outClk, outClkN
  );
endinterface // iac_link_if

// >>> rtl/iac_device.sv
// Converter end: two interleaved cores, fifteen-sample output pipeline,
// strap decoding and the reset-driven calibration sequence.
// Assumes the capture end drives sampleClk from the same sys_clk.
`timescale 1ns/1ps
`include "iac_cfg.svh"
module iac_device
  import iac_pkg::*;
#(
  parameter int unsigned CAL_CYCLES = `IAC_CAL_NOM_MS * `IAC_CLK_KHZ
) (
  input wire logic sys_clk,
  input wire logic rst,
  iac_link_if.dev link,
  input wire logic [12:0] analogIn,
  input wire logic signed [7:0] coreErrA,
  input wire logic signed [7:0] coreErrB,
  input wire logic signed [7:0] skewTrimA,
  input wire logic signed [7:0] skewTrimB,
  output logic calBusy
);

  localparam int unsigned CAL_MAX = `IAC_CAL_MAX_MS * `IAC_CLK_KHZ;
  localparam int unsigned CAL_USED = (CAL_CYCLES > CAL_MAX) ? CAL_MAX : CAL_CYCLES;

  function automatic logic [12:0] convert(input logic [12:0] level,
                                          input logic signed [7:0] err,
                                          input logic signed [7:0] trim);
    logic signed [14:0] v;
    v = $signed({2'b00, level}) + $signed({{7{err[7]}}, err}) - $signed({{7{trim[7]}}, trim});
    if (v < 15'sh0000) begin
      convert = 13'h0000;
    end else if (v >= $signed({3'b000, `IAC_FULL_SCALE})) begin
      convert = {1'b1, `IAC_FULL_SCALE};
    end else begin
      convert = {1'b0, v[11:0]};
    end
  endfunction

  function automatic logic [11:0] encode(input logic [11:0] code, input iac_strap_type fmt);
    case (fmt)
      STRAP_LOW: encode = code ^ 12'h800;
      STRAP_OPEN: encode = code ^ (code >> 1);
      default: encode = code;
    endcase
  endfunction

  iac_cal_state_type state_q;
  logic [31:0] calCnt_q;
  logic [7:0] porCnt_q;
  logic resetPrev_q;
  logic sampleClkPrev_q;
  logic divPhase_q;
  logic coreSel_q;
  logic signed [7:0] trimA_q;
  logic signed [7:0] trimB_q;
  logic [12:0] pipe_q [0:`IAC_LATENCY-1];
  logic [11:0] dataOut_q;
  logic [11:0] dataOutN_q;
  logic ovr_q;
  logic ovrN_q;
  logic outClk_q;
  logic outClkN_q;
  logic devRstOe_q;
  logic sampleEv;
  logic resetRise;
  logic powerOn;
  logic differential;
  logic [12:0] converted;
  logic [11:0] dataOut_d;
  logic ovr_d;
  logic outClk_d;

  assign powerOn = (link.powerStateStrap == STRAP_OPEN);
  assign differential = (link.outputStyleStrap != STRAP_LOW);
  assign resetRise = link.resetPin & ~resetPrev_q;
  // divide-by-two on low strap; high strap is not allowed and acts as open
  assign sampleEv = link.sampleClk & ~sampleClkPrev_q & powerOn &
                    ((link.dividerStrap != STRAP_LOW) | divPhase_q);
  // skew trims only retime the core clock, which this logic does not model
  assign converted = (state_q != ST_RUN) ? 13'h0000 :
                     (coreSel_q ? convert(analogIn, coreErrB, trimB_q) :
                                  convert(analogIn, coreErrA, trimA_q));

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sampleClkPrev_q <= 1'b0;
      resetPrev_q <= 1'b0;
    end else begin
      sampleClkPrev_q <= link.sampleClk;
      resetPrev_q <= link.resetPin;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      porCnt_q <= 8'h00;
      devRstOe_q <= 1'b1;
    end else if (porCnt_q != 8'(`IAC_POR_CYCLES)) begin
      porCnt_q <= porCnt_q + 8'h01;
    end else begin
      devRstOe_q <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_q <= ST_HOLD;
      calCnt_q <= 32'h0000_0000;
    end else if (!link.resetPin) begin
      state_q <= ST_HOLD;
      calCnt_q <= 32'h0000_0000;
    end else begin
      case (state_q)
        ST_HOLD: begin
          if (resetRise) begin
            state_q <= ST_CAL;
          end
        end
        ST_CAL: begin
          if (calCnt_q >= CAL_USED - 1) begin
            state_q <= ST_RUN;
          end else begin
            calCnt_q <= calCnt_q + 32'h0000_0001;
          end
        end
        ST_RUN: state_q <= ST_RUN;
        default: state_q <= ST_HOLD;
      endcase
    end
  end

  // offset trims measured at calibration start
  // a low serial output spoils the measurement
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      trimA_q <= 8'sh00;
      trimB_q <= 8'sh00;
    end else if (state_q == ST_HOLD && resetRise) begin
      trimA_q <= link.serialOutPin ? coreErrA : 8'sh00;
      trimB_q <= link.serialOutPin ? coreErrB : 8'sh00;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      coreSel_q <= 1'b0;
      divPhase_q <= 1'b0;
    end else begin
      if (link.sampleClk & ~sampleClkPrev_q) begin
        divPhase_q <= ~divPhase_q;
      end
      if (sampleEv) begin
        coreSel_q <= ~coreSel_q;
      end
    end
  end

  // fifteen stages ahead of the output register
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < `IAC_LATENCY; i++) begin
        pipe_q[i] <= 13'h0000;
      end
    end else if (sampleEv) begin
      pipe_q[0] <= converted;
      for (int i = 1; i < `IAC_LATENCY; i++) begin
        pipe_q[i] <= pipe_q[i-1];
      end
    end
  end

  assign dataOut_d = sampleEv ? encode(pipe_q[`IAC_LATENCY-1][11:0], link.codeFormatStrap) :
                                dataOut_q;
  assign ovr_d = (!link.resetPin || state_q != ST_RUN) ? 1'b1 :
                 (sampleEv ? pipe_q[`IAC_LATENCY-1][12] : ovr_q);
  assign outClk_d = (!link.resetPin || !powerOn) ? 1'b0 : (outClk_q ^ sampleEv);

  // complements idle low when single-ended
  // Complements follow the style strap every cycle, so a style change is not
  // held back until the next sample event, which never comes in nap.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      dataOut_q <= 12'h000;
      dataOutN_q <= 12'h000;
      ovr_q <= 1'b1;
      ovrN_q <= 1'b0;
      outClk_q <= 1'b0;
      outClkN_q <= 1'b0;
    end else begin
      dataOut_q <= dataOut_d;
      dataOutN_q <= differential ? ~dataOut_d : 12'h000;
      ovr_q <= ovr_d;
      ovrN_q <= differential & ~ovr_d;
      outClk_q <= outClk_d;
      outClkN_q <= differential & ~outClk_d;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      calBusy <= 1'b1;
    end else begin
      calBusy <= (state_q != ST_RUN);
    end
  end

  assign link.devRstOe = devRstOe_q;
  assign link.dataOut = dataOut_q;
  assign link.dataOutN = dataOutN_q;
  assign link.ovr = ovr_q;
  assign link.ovrN = ovrN_q;
  assign link.outClk = outClk_q;
  assign link.outClkN = outClkN_q;
  // serial port not modelled; lines released.
  // released serial output keeps its pull-up high.
  assign link.devSdioOut = 1'b0;
  assign link.devSdioOe = 1'b0;
  assign link.devSerialOut = 1'b0;
  assign link.devSerialOe = 1'b0;

endmodule // iac_device

// >>> rtl/iac_host.sv
// Capture end: sample clock source, reset driver, strap settings and
// sample capture; straps, reset and readback steered over an APB slave.
// Assumes the converter end runs on the same sys_clk.
`timescale 1ns/1ps
`include "iac_cfg.svh"
module iac_host
  import iac_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  iac_link_if.host link,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);

  logic [7:0] ctrl_q;
  logic [7:0] halfCnt_q;
  logic sampleClk_q;
  logic [7:0] rstCnt_q;
  logic hostRstOe_q;
  logic outClkPrev_q;
  logic valid_q;
  logic [12:0] sample_q;
  logic [31:0] count_q;
  logic access;
  logic mapped;

  assign access = psel & penable;
  assign mapped = (paddr == `IAC_REG_CTRL) || (paddr == `IAC_REG_STATUS) ||
                  (paddr == `IAC_REG_SAMPLE) || (paddr == `IAC_REG_COUNT);

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      halfCnt_q <= 8'h00;
      sampleClk_q <= 1'b0;
    end else if (halfCnt_q == 8'(`IAC_SAMPLE_HALF - 1)) begin
      halfCnt_q <= 8'h00;
      sampleClk_q <= ~sampleClk_q;
    end else begin
      halfCnt_q <= halfCnt_q + 8'h01;
    end
  end

  // hold reset one whole sample clock
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ctrl_q <= `IAC_CTRL_RESET;
      rstCnt_q <= 8'h00;
      hostRstOe_q <= 1'b0;
    end else begin
      if (access && pwrite && paddr == `IAC_REG_CTRL) begin
        ctrl_q <= pwdata[7:0];
      end
      if (access && pwrite && paddr == `IAC_REG_CTRL && pwdata[`IAC_CTRL_RECAL]) begin
        rstCnt_q <= 8'(2 * `IAC_SAMPLE_HALF);
        hostRstOe_q <= 1'b1;
      end else if (rstCnt_q != 8'h00) begin
        rstCnt_q <= rstCnt_q - 8'h01;
      end else begin
        hostRstOe_q <= 1'b0;
      end
    end
  end

  // samples valid once over-range falls after reset
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      outClkPrev_q <= 1'b0;
      valid_q <= 1'b0;
      sample_q <= 13'h0000;
      count_q <= 32'h0000_0000;
    end else begin
      outClkPrev_q <= link.outClk;
      if (!link.resetPin) begin
        valid_q <= 1'b0;
      end else if (!link.ovr) begin
        valid_q <= 1'b1;
      end
      if (link.outClk != outClkPrev_q && valid_q) begin
        sample_q <= {link.ovr, link.dataOut};
        count_q <= count_q + 32'h0000_0001;
      end
    end
  end

  // Zero-wait slave: reads are registered so data lines up with pready.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped;
      case (paddr)
        `IAC_REG_CTRL: prdata <= {24'h000000, ctrl_q};
        `IAC_REG_STATUS: prdata <= {29'h0, link.ovr, link.resetPin, valid_q};
        `IAC_REG_SAMPLE: prdata <= {19'h0, sample_q};
        `IAC_REG_COUNT: prdata <= count_q;
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  assign link.sampleClk = sampleClk_q;
  assign link.dividerStrap = iac_strap_type'(ctrl_q[`IAC_CTRL_DIV]);
  assign link.outputStyleStrap = iac_strap_type'(ctrl_q[`IAC_CTRL_STYLE]);
  assign link.powerStateStrap = iac_strap_type'(ctrl_q[`IAC_CTRL_POWER]);
  assign link.codeFormatStrap = iac_strap_type'(ctrl_q[`IAC_CTRL_FMT]);
  assign link.hostRstOe = hostRstOe_q;
  // select held high, data line released
  assign link.serialSelectLow = 1'b1;
  assign link.serialClk = 1'b0;
  assign link.hostSdioOut = 1'b0;
  assign link.hostSdioOe = 1'b0;

endmodule // iac_host

// >>> bench/iac_link_properties.sv
// Concurrent checks on the signals of the converter link.
// Assumes one sys_clk domain with rst asynchronous and active high.
`timescale 1ns/1ps
module iac_link_properties
  import iac_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic resetPin,
  input wire iac_strap_type outputStyleStrap,
  input wire iac_strap_type powerStateStrap,
  input wire logic [11:0] dataOut,
  input wire logic [11:0] dataOutN,
  input wire logic ovr,
  input wire logic ovrN,
  input wire logic outClk,
  input wire logic outClkN,
  input wire logic serialOutPin
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic [3:0] idleCnt_q;
  // A stalled output clock shows up as a long idle run; the limit covers divide by two.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      idleCnt_q <= 4'h0;
    end else if (!resetPin || powerStateStrap != STRAP_OPEN || $changed(outClk)) begin
      idleCnt_q <= 4'h0;
    end else if (idleCnt_q != 4'hf) begin
      idleCnt_q <= idleCnt_q + 4'h1;
    end
  end
  a_ovr_on_reset: assert property (!resetPin |=> ovr)
    else $error("over-range low while reset pin low");
  a_ovr_held_cal: assert property ($rose(resetPin) |-> ovr [*8])
    else $error("over-range dropped early in calibration");
  a_clk_low_reset: assert property (!resetPin |=> !outClk)
    else $error("output clock high while reset pin low");
  a_clk_keeps_running: assert property (idleCnt_q <= 4'h9)
    else $error("output clock stalled in normal power");
  a_single_ended_quiet: assert property ((outputStyleStrap == STRAP_LOW) [*3] |->
    dataOutN == 12'h0 && !ovrN && !outClkN)
    else $error("complement outputs active in single-ended style");
  a_diff_pairs_true: assert property ((outputStyleStrap != STRAP_LOW) [*3] |->
    dataOutN == ~dataOut && ovrN == !ovr && outClkN == !outClk)
    else $error("complement outputs do not mirror true outputs");
  a_nap_clock_quiet: assert property ((powerStateStrap != STRAP_OPEN) [*3] |-> !outClk)
    else $error("output clock high in nap or sleep");
  a_data_on_event: assert property (resetPin && $past(resetPin) && $changed(dataOut) |->
    $changed(outClk))
    else $error("data changed without an output clock edge");
  a_serial_out_high: assert property (serialOutPin)
    else $error("serial output pin pulled low");
  c_cal_done: cover property ($fell(ovr));
  c_reset_rise: cover property ($rose(resetPin));
  c_single_ended: cover property (outputStyleStrap == STRAP_LOW && outClk);
  c_nap: cover property (powerStateStrap != STRAP_OPEN);
endmodule // iac_link_properties

// >>> bench/interleaved_adc_calibration_output_test.sv
// Self-checking bench driving the capture end over APB and the converter's inputs.
// Assumes the rtl files on the path and a 40 MHz sys_clk.
`timescale 1ns/1ps
`include "iac_cfg.svh"
`define CHK(g, e) begin checkCount++; if ((g) !== (e)) begin fails++; \
  $display("BAD t=%0t got %h exp %h", $time, g, e); end end
module interleaved_adc_calibration_output_test;
  import iac_pkg::*;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [12:0] analogIn = 13'h0000;
  logic signed [7:0] coreErrA = 8'sh05;
  logic signed [7:0] coreErrB = -8'sh03;
  logic signed [7:0] skewTrimA = 8'sh07;
  logic signed [7:0] skewTrimB = -8'sh02;
  logic calBusy;
  logic [31:0] rd;
  logic er;
  logic [12:0] fsIn [3] = '{13'h0fff, 13'h1800, 13'h0ffe};
  int fails = 0;
  int checkCount = 0;
  int cyc = 0;
  int t0;
  always #12.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) cyc <= cyc + 1;
  iac_link_if iac_link_if_i ();
  iac_device #(.CAL_CYCLES(50)) iac_device_i (.sys_clk(sys_clk), .rst(rst),
    .link(iac_link_if_i), .analogIn(analogIn), .coreErrA(coreErrA), .coreErrB(coreErrB),
    .skewTrimA(skewTrimA), .skewTrimB(skewTrimB), .calBusy(calBusy));
  iac_host iac_host_i (.sys_clk(sys_clk), .rst(rst), .link(iac_link_if_i), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));
  iac_link_properties iac_link_properties_i (.sys_clk(sys_clk), .rst(rst),
    .resetPin(iac_link_if_i.resetPin), .outputStyleStrap(iac_link_if_i.outputStyleStrap),
    .powerStateStrap(iac_link_if_i.powerStateStrap), .dataOut(iac_link_if_i.dataOut),
    .dataOutN(iac_link_if_i.dataOutN), .ovr(iac_link_if_i.ovr), .ovrN(iac_link_if_i.ovrN),
    .outClk(iac_link_if_i.outClk), .outClkN(iac_link_if_i.outClkN),
    .serialOutPin(iac_link_if_i.serialOutPin));
  function automatic logic [11:0] enc(input logic [1:0] f, input logic [11:0] v);
    case (f)
      2'h0: enc = v ^ 12'h800;
      2'h1: enc = v ^ (v >> 1);
      default: enc = v;
    endcase
  endfunction
  // One APB transfer; the request holds until pready is seen at a rising edge.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask
  // Waits for k output clock edges, each edge carrying one sample.
  task automatic tog(input int k);
    logic last;
    int n;
    last = iac_link_if_i.outClk;
    n = 0;
    while (k > 0 && n < 400) begin
      @(posedge sys_clk);
      n++;
      if (iac_link_if_i.outClk !== last) begin
        last = iac_link_if_i.outClk;
        k--;
      end
    end
    `CHK(k, 0)
  endtask
  task automatic calWait();
    int n;
    n = 0;
    repeat (30) @(posedge sys_clk);
    `CHK(calBusy, 1'b1)
    `CHK(iac_link_if_i.ovr, 1'b1)
    while (iac_link_if_i.ovr !== 1'b0 && n < 600) begin
      @(posedge sys_clk);
      n++;
    end
    repeat (2) @(posedge sys_clk);
    `CHK(iac_link_if_i.ovr, 1'b0)
    `CHK(calBusy, 1'b0)
  endtask
  task automatic wrapUp();
    $display("comparisons %0d mismatches %0d", checkCount, fails);
    if (fails == 0 && checkCount > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge sys_clk);
    fails++;
    $display("BAD t=%0t watchdog expired", $time);
    wrapUp();
  end
  initial begin
    repeat (5) @(posedge sys_clk);
    `CHK(iac_link_if_i.ovr, 1'b1)
    `CHK(iac_link_if_i.outClk, 1'b0)
    rst <= 1'b0;
    @(posedge sys_clk);
    apb(1'b0, `IAC_REG_CTRL, 32'h0);
    `CHK(rd, 32'h55)
    apb(1'b0, 8'h10, 32'h0);
    `CHK({er, rd}, 33'h100000000)
    calWait();
    analogIn <= 13'h0123;
    apb(1'b1, `IAC_REG_CTRL, 32'h95);
    tog(20);
    analogIn <= 13'h05a3;
    tog(15);
    `CHK(iac_link_if_i.dataOut, 12'h123)
    tog(1);
    `CHK(iac_link_if_i.dataOut, 12'h5a3)
    for (int f = 0; f < 3; f++) begin
      apb(1'b1, `IAC_REG_CTRL, 32'h15 | (f << 6));
      tog(17);
      `CHK(iac_link_if_i.dataOut, enc(f[1:0], 12'h5a3))
    end
    for (int i = 0; i < 3; i++) begin
      analogIn <= fsIn[i];
      tog(17);
      `CHK(iac_link_if_i.dataOut, (fsIn[i] > 13'h0fff) ? 12'hfff : fsIn[i][11:0])
      `CHK(iac_link_if_i.ovr, fsIn[i] >= 13'h0fff)
    end
    apb(1'b1, `IAC_REG_CTRL, 32'h91);
    tog(4);
    `CHK({iac_link_if_i.dataOutN, iac_link_if_i.ovrN, iac_link_if_i.outClkN}, 14'h0)
    for (int d = 0; d < 3; d++) begin
      apb(1'b1, `IAC_REG_CTRL, 32'h94 | d);
      tog(2);
      t0 = cyc;
      tog(1);
      `CHK(cyc - t0, (d == 0) ? 8 : 4)
    end
    `CHK(iac_link_if_i.dataOutN, ~iac_link_if_i.dataOut)
    for (int p = 0; p < 3; p += 2) begin
      apb(1'b1, `IAC_REG_CTRL, 32'h85 | (p << 4));
      repeat (20) @(posedge sys_clk);
      `CHK(iac_link_if_i.outClk, 1'b0)
    end
    apb(1'b1, `IAC_REG_CTRL, 32'h95);
    tog(2);
    analogIn <= 13'h0200;
    apb(1'b1, `IAC_REG_CTRL, 32'h195);
    repeat (2) @(posedge sys_clk);
    `CHK(iac_link_if_i.resetPin, 1'b0)
    `CHK(iac_link_if_i.outClk, 1'b0)
    calWait();
    tog(17);
    apb(1'b0, `IAC_REG_STATUS, 32'h0);
    `CHK(rd[2:0], 3'h3)
    apb(1'b0, `IAC_REG_SAMPLE, 32'h0);
    `CHK(rd, 32'h200)
    tog(1);
    apb(1'b0, `IAC_REG_COUNT, 32'h0);
    t0 = rd;
    tog(4);
    apb(1'b0, `IAC_REG_COUNT, 32'h0);
    `CHK(rd - t0, 32'h4)
    wrapUp();
  end
endmodule // interleaved_adc_calibration_output_test
